//--- rtl/clk_sel_pkg.sv
// Types shared by the clock selector modules
package clk_sel_pkg;
	typedef enum logic [2:0] {
		PM_RUN    = 3'b000,
		PM_IDLE   = 3'b001,
		PM_SLEEP  = 3'b010,
		PM_STOP   = 3'b011,
		PM_WARMUP = 3'b100
	} power_mode_e;
endpackage

//--- rtl/clk_sel_regs.svh
// Register map, field positions, reset values and counts of the clock selector
`ifndef CLK_SEL_REGS_SVH
`define CLK_SEL_REGS_SVH

`define ADDR_OSC_CTRL   8'h00
`define ADDR_PLL_SEL    8'h04
`define ADDR_SYS_SEL    8'h08
`define ADDR_DIV_CTRL   8'h0C
`define ADDR_STBY_CTRL  8'h10

`define OSC_XTEN_BIT    9
`define OSC_XEN_BIT     8
`define OSC_WUPT_MSB    6
`define OSC_WUPT_LSB    4
`define OSC_WUPSEL_BIT  3
`define OSC_MULTIPLIER_POWER_ON_BIT   2
`define OSC_WARMUP_RUNNING_FLAG_BIT    1
`define OSC_WARMUP_START_BIT   0
`define HS_SOURCE_USE_MULTIPLIER_BIT      0
`define SYSCK_BIT       1
`define SYSFLG_BIT      0
`define GEAR_MSB        1
`define GEAR_LSB        0
`define PRCK_MSB        6
`define PRCK_LSB        4
`define STBY_MSB        2
`define STBY_LSB        0

`define RST_XEN         1'b1
`define RST_XTEN        1'b1
`define RST_MULTIPLIER_POWER_ON       1'b0
`define RST_WUPT        3'h0
`define RST_WUPSEL      1'b0
`define RST_HS_SOURCE_USE_MULTIPLIER      1'b0
`define RST_SYSCK       1'b0
`define RST_GEAR        2'h0
`define RST_PRCK        3'h0
`define RST_STBY        3'h3

`define STBY_STOP       3'h1
`define STBY_SLEEP      3'h2
`define STBY_IDLE       3'h3

`define TICK_TIMER_LAST 5'h1F
`define PRCK_MAX        3'h5
`define WU_NONE         3'h0
`define WU_HS_EXP_OFS   5'h09
`define WU_LS_EXP_LO    5'h05
`define WU_LS_EXP_HI    5'h0B
`define WU_LS_HI_CODE   3'h4
`define WU_CNT_W        19
`define PLL_CNT_W       8
`define PLL_CNT_MAX     8'hFF
`define PLL_QUARTER_SH  2

`endif

//--- rtl/clk_source_ctrl.sv
// Clock source selection, dividers, low-power gating and warm-up control
// Notes on behaviour
// - Select bit: 0 oscillator, 1 multiplier; resets 0
// - System select bit 1: 0 high, 1 low
// - Status flag bit 0 shows actual source
// - Flag follows request only after switch lag
// - Multiplier output is four times oscillator
// - High-speed gear divides by 1,2,4,8
// - Prescaler input divides peripheral clock 1..32
// - Core clock is system clock, stopped when low-power
// - Tick timer clock is oscillator over 32
// - Reset: oscillators run, multiplier off, gear 1
// - After reset all clocks but the tick timer clock equal oscillator
// - Multiplier runs only once its power bit set
// - Wake from stop/sleep auto-runs warm-up first
// - Multiplier disabled during stop and sleep
// - Warm-up select: 0 high-speed, 1 low-speed ticks
// - Warm-up code sets length; 000 means none
// - Writing 1 starts warm-up; 0 ignored
// - Warm-up flag high while counting
`timescale 1ns/1ps
`include "clk_sel_regs.svh"
module clk_source_ctrl
	import clk_sel_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// Register port
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	// Oscillator ticks
	input  wire logic        hs_osc_tick_in,
	input  wire logic        ls_osc_tick_in,
	// Low-power control
	input  wire logic        lp_enter_in,
	input  wire logic        wake_irq_in,
	// Analog enables
	output logic             hs_osc_enable_out,
	output logic             ls_osc_enable_out,
	output logic             multiplier_power_on_out,
	// Derived clock ticks and mode
	output logic             high_speed_clock_out,
	output logic             sysclk_tick_out,
	output logic             core_free_clock_out,
	output logic             prescaler_input_clock_out,
	output logic             tick_timer_clock_out,
	output logic      [2:0]  power_mode_out
);
	// Software settings
	logic        xen_ff;
	logic        nxt_xen;
	logic        xten_ff;
	logic        nxt_xten;
	logic        multiplier_power_on_ff;
	logic        nxt_multiplier_power_on;
	logic [2:0]  wupt_ff;
	logic [2:0]  nxt_wupt;
	logic        wupsel_ff;
	logic        nxt_wupsel;
	logic        hs_source_use_multiplier_ff;
	logic        nxt_hs_source_use_multiplier;
	logic        sysck_ff;
	logic        nxt_sysck;
	logic [1:0]  gear_ff;
	logic [1:0]  nxt_gear;
	logic [2:0]  prck_ff;
	logic [2:0]  nxt_prck;
	logic [2:0]  stby_ff;
	logic [2:0]  nxt_stby;
	logic        sw_start;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// Clock path state
	logic        flag_ff;
	logic        nxt_flag;
	logic [2:0]  gear_cnt_ff;
	logic [2:0]  nxt_gear_cnt;
	logic [4:0]  pre_cnt_ff;
	logic [4:0]  nxt_pre_cnt;
	logic [4:0]  st_cnt_ff;
	logic [4:0]  nxt_st_cnt;
	logic        hs_ff;
	logic        nxt_hs;
	logic        sys_ff;
	logic        nxt_sys;
	logic        core_ff;
	logic        nxt_core;
	logic        pre_ff;
	logic        nxt_pre;
	logic        st_ff;
	logic        nxt_st;
	logic        pll_tick;
	logic        hs_tick;
	logic        gear_tick;
	logic        src_tick;
	logic [2:0]  gear_mask;
	logic [4:0]  pre_mask;

	// Power mode state
	power_mode_e mode_ff;
	power_mode_e nxt_mode;
	logic        auto_start;
	logic        deep_sleep;

	warmup_if wu ();

	// Register writes
	always_comb
	begin
		nxt_xen = xen_ff;
		nxt_xten = xten_ff;
		nxt_multiplier_power_on = multiplier_power_on_ff;
		nxt_wupt = wupt_ff;
		nxt_wupsel = wupsel_ff;
		nxt_hs_source_use_multiplier = hs_source_use_multiplier_ff;
		nxt_sysck = sysck_ff;
		nxt_gear = gear_ff;
		nxt_prck = prck_ff;
		nxt_stby = stby_ff;
		sw_start = 1'b0;
		if (wr_in)
		begin
			unique case (addr_in)
				`ADDR_OSC_CTRL:
				begin
					nxt_xten = wdata_in[`OSC_XTEN_BIT];
					nxt_xen = wdata_in[`OSC_XEN_BIT];
					nxt_wupt = wdata_in[`OSC_WUPT_MSB:`OSC_WUPT_LSB];
					nxt_wupsel = wdata_in[`OSC_WUPSEL_BIT];
					nxt_multiplier_power_on = wdata_in[`OSC_MULTIPLIER_POWER_ON_BIT];
					sw_start = wdata_in[`OSC_WARMUP_START_BIT];
				end
				`ADDR_PLL_SEL:
					nxt_hs_source_use_multiplier = wdata_in[`HS_SOURCE_USE_MULTIPLIER_BIT];
				`ADDR_SYS_SEL:
					nxt_sysck = wdata_in[`SYSCK_BIT];
				`ADDR_DIV_CTRL:
				begin
					nxt_gear = wdata_in[`GEAR_MSB:`GEAR_LSB];
					nxt_prck = wdata_in[`PRCK_MSB:`PRCK_LSB];
				end
				`ADDR_STBY_CTRL:
					nxt_stby = wdata_in[`STBY_MSB:`STBY_LSB];
				default:
					nxt_xen = xen_ff;
			endcase
		end
	end

	// Register reads: data stand one cycle, zero otherwise
	always_comb
	begin
		nxt_rdata = '0;
		if (rd_in)
		begin
			unique case (addr_in)
				`ADDR_OSC_CTRL:
				begin
					nxt_rdata[`OSC_XTEN_BIT] = xten_ff;
					nxt_rdata[`OSC_XEN_BIT] = xen_ff;
					nxt_rdata[`OSC_WUPT_MSB:`OSC_WUPT_LSB] = wupt_ff;
					nxt_rdata[`OSC_WUPSEL_BIT] = wupsel_ff;
					nxt_rdata[`OSC_MULTIPLIER_POWER_ON_BIT] = multiplier_power_on_ff;
					nxt_rdata[`OSC_WARMUP_RUNNING_FLAG_BIT] = wu.running;
				end
				`ADDR_PLL_SEL:
					nxt_rdata[`HS_SOURCE_USE_MULTIPLIER_BIT] = hs_source_use_multiplier_ff;
				`ADDR_SYS_SEL:
				begin
					nxt_rdata[`SYSCK_BIT] = sysck_ff;
					nxt_rdata[`SYSFLG_BIT] = flag_ff;
				end
				`ADDR_DIV_CTRL:
				begin
					nxt_rdata[`GEAR_MSB:`GEAR_LSB] = gear_ff;
					nxt_rdata[`PRCK_MSB:`PRCK_LSB] = prck_ff;
				end
				`ADDR_STBY_CTRL:
					nxt_rdata[`STBY_MSB:`STBY_LSB] = stby_ff;
				default:
					nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			xen_ff <= `RST_XEN;
			xten_ff <= `RST_XTEN;
			multiplier_power_on_ff <= `RST_MULTIPLIER_POWER_ON;
			wupt_ff <= `RST_WUPT;
			wupsel_ff <= `RST_WUPSEL;
			hs_source_use_multiplier_ff <= `RST_HS_SOURCE_USE_MULTIPLIER;
			sysck_ff <= `RST_SYSCK;
			gear_ff <= `RST_GEAR;
			prck_ff <= `RST_PRCK;
			stby_ff <= `RST_STBY;
			rdata_ff <= '0;
		end
		else
		begin
			xen_ff <= nxt_xen;
			xten_ff <= nxt_xten;
			multiplier_power_on_ff <= nxt_multiplier_power_on;
			wupt_ff <= nxt_wupt;
			wupsel_ff <= nxt_wupsel;
			hs_source_use_multiplier_ff <= nxt_hs_source_use_multiplier;
			sysck_ff <= nxt_sysck;
			gear_ff <= nxt_gear;
			prck_ff <= nxt_prck;
			stby_ff <= nxt_stby;
			rdata_ff <= nxt_rdata;
		end
	end

	// Power mode sequencing
	always_comb
	begin
		nxt_mode = mode_ff;
		auto_start = 1'b0;
		unique case (mode_ff)
			PM_RUN:
				if (lp_enter_in)
				begin
					// Reserved standby codes leave the core running
					if (stby_ff == `STBY_STOP)
						nxt_mode = PM_STOP;
					else if (stby_ff == `STBY_SLEEP)
						nxt_mode = PM_SLEEP;
					else if (stby_ff == `STBY_IDLE)
						nxt_mode = PM_IDLE;
				end
			PM_IDLE:
				if (wake_irq_in)
					nxt_mode = PM_RUN;
			PM_SLEEP, PM_STOP:
				if (wake_irq_in)
				begin
					nxt_mode = PM_WARMUP;
					auto_start = 1'b1;
				end
			PM_WARMUP:
				if (!wu.running)
					nxt_mode = PM_RUN;
			default:
				nxt_mode = PM_RUN;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			mode_ff <= PM_RUN;
		else
			mode_ff <= nxt_mode;
	end

	assign deep_sleep = (mode_ff == PM_SLEEP) || (mode_ff == PM_STOP);

	// Warm-up timer hookup
	assign wu.start = sw_start | auto_start;
	// The write that starts a count also sets its length and source
	assign wu.use_ls = nxt_wupsel;
	assign wu.time_code = nxt_wupt;
	assign wu.hs_tick = hs_osc_tick_in;
	assign wu.ls_tick = ls_osc_tick_in;

	warmup_timer u_warmup (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.wu         (wu.timer)
	);

	pll_quad_tick u_pll (
		.clk_in      (clk_in),
		.sys_rst_in  (sys_rst_in),
		.enable_in   (multiplier_power_on_out),
		.ref_tick_in (hs_osc_tick_in),
		.tick_out    (pll_tick)
	);

	// Clock path
	always_comb
	begin
		hs_tick = hs_source_use_multiplier_ff ? pll_tick : hs_osc_tick_in;
		unique case (gear_ff)
			2'h0: gear_mask = 3'h0;
			2'h1: gear_mask = 3'h1;
			2'h2: gear_mask = 3'h3;
			2'h3: gear_mask = 3'h7;
		endcase
		gear_tick = hs_tick && ((gear_cnt_ff & gear_mask) == gear_mask);
		nxt_gear_cnt = hs_tick ? gear_cnt_ff + 3'h1 : gear_cnt_ff;
		// Codes above the largest divider saturate at divide by 32
		if (prck_ff > `PRCK_MAX)
			pre_mask = 5'h1F;
		else
			pre_mask = (5'h1 << prck_ff) - 5'h1;
		nxt_pre_cnt = gear_tick ? pre_cnt_ff + 5'h1 : pre_cnt_ff;
		nxt_st_cnt = hs_osc_tick_in ? st_cnt_ff + 5'h1 : st_cnt_ff;
		// Flag moves only on a tick of the requested source, so a
		// source that is not oscillating keeps the old one in use
		src_tick = sysck_ff ? ls_osc_tick_in : gear_tick;
		nxt_flag = flag_ff;
		if ((sysck_ff != flag_ff) && src_tick)
			nxt_flag = sysck_ff;
		nxt_hs = hs_tick;
		nxt_sys = (flag_ff ? ls_osc_tick_in : gear_tick) &&
			!deep_sleep && (mode_ff != PM_WARMUP);
		nxt_core = (flag_ff ? ls_osc_tick_in : gear_tick) &&
			(mode_ff == PM_RUN);
		nxt_pre = gear_tick && ((pre_cnt_ff & pre_mask) == pre_mask) &&
			!deep_sleep && (mode_ff != PM_WARMUP);
		nxt_st = hs_osc_tick_in && (st_cnt_ff == `TICK_TIMER_LAST);
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			flag_ff <= 1'b0;
			gear_cnt_ff <= '0;
			pre_cnt_ff <= '0;
			st_cnt_ff <= '0;
			hs_ff <= 1'b0;
			sys_ff <= 1'b0;
			core_ff <= 1'b0;
			pre_ff <= 1'b0;
			st_ff <= 1'b0;
		end
		else
		begin
			flag_ff <= nxt_flag;
			gear_cnt_ff <= nxt_gear_cnt;
			pre_cnt_ff <= nxt_pre_cnt;
			st_cnt_ff <= nxt_st_cnt;
			hs_ff <= nxt_hs;
			sys_ff <= nxt_sys;
			core_ff <= nxt_core;
			pre_ff <= nxt_pre;
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign rdata_out = rdata_ff;
	assign hs_osc_enable_out = xen_ff && (mode_ff != PM_STOP);
	assign ls_osc_enable_out = xten_ff;
	assign multiplier_power_on_out = multiplier_power_on_ff && !deep_sleep;
	assign high_speed_clock_out = hs_ff;
	assign sysclk_tick_out = sys_ff;
	assign core_free_clock_out = core_ff;
	assign prescaler_input_clock_out = pre_ff;
	assign tick_timer_clock_out = st_ff;
	assign power_mode_out = mode_ff;
endmodule

//--- rtl/pll_quad_tick.sv
// Times four tick multiplier locked to the measured oscillator period
`timescale 1ns/1ps
`include "clk_sel_regs.svh"
module pll_quad_tick
	import clk_sel_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// Control and reference
	input  wire logic enable_in,
	input  wire logic ref_tick_in,
	// Multiplied tick
	output logic      tick_out
);
	logic [`PLL_CNT_W-1:0] cnt_ff;
	logic [`PLL_CNT_W-1:0] nxt_cnt;
	logic [`PLL_CNT_W-1:0] period_ff;
	logic [`PLL_CNT_W-1:0] nxt_period;
	logic                  valid_ff;
	logic                  nxt_valid;
	logic                  tick_ff;
	logic                  nxt_tick;
	logic [`PLL_CNT_W-1:0] quarter;

	always_comb
	begin
		// A reference with fewer than four system clocks per period cannot be
		// quadrupled on this clock, so the output then stays quiet
		quarter = period_ff >> `PLL_QUARTER_SH;
		nxt_cnt = (cnt_ff == `PLL_CNT_MAX) ? cnt_ff
			: cnt_ff + `PLL_CNT_W'(1);
		nxt_period = period_ff;
		nxt_valid = valid_ff;
		if (!enable_in)
		begin
			nxt_valid = 1'b0;
			nxt_cnt = '0;
		end
		else if (ref_tick_in)
		begin
			nxt_period = nxt_cnt;
			nxt_valid = 1'b1;
			nxt_cnt = '0;
		end
		nxt_tick = enable_in && valid_ff && (quarter != '0) &&
			((cnt_ff == '0) || (cnt_ff == quarter) ||
			(cnt_ff == (quarter << 1)) ||
			(cnt_ff == `PLL_CNT_W'(quarter + (quarter << 1))));
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			cnt_ff <= '0;
			period_ff <= '0;
			valid_ff <= 1'b0;
			tick_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			period_ff <= nxt_period;
			valid_ff <= nxt_valid;
			tick_ff <= nxt_tick;
		end
	end

	assign tick_out = tick_ff;
endmodule

//--- rtl/warmup_if.sv
// Control and status link between the selector and its warm-up timer
`timescale 1ns/1ps
interface warmup_if;
	logic       start;
	logic       use_ls;
	logic [2:0] time_code;
	logic       hs_tick;
	logic       ls_tick;
	logic       running;
	modport ctrl  (output start, use_ls, time_code, hs_tick, ls_tick,
		input running);
	modport timer (input start, use_ls, time_code, hs_tick, ls_tick,
		output running);
endinterface

//--- rtl/warmup_timer.sv
// Warm-up counter on oscillator ticks with selectable length
`timescale 1ns/1ps
`include "clk_sel_regs.svh"
module warmup_timer
	import clk_sel_pkg::*;
(
	// Clock and reset
	input  wire logic   clk_in,
	input  wire logic   sys_rst_in,
	// Control link
	warmup_if.timer     wu
);
	logic [`WU_CNT_W-1:0] count_ff;
	logic [`WU_CNT_W-1:0] nxt_count;
	logic                 running_ff;
	logic                 nxt_running;
	logic [4:0]           exp_bits;
	logic [`WU_CNT_W-1:0] last_count;
	logic                 tick;

	always_comb
	begin
		// Low-speed codes jump from 2^8 to 2^15 at code 100
		if (!wu.use_ls)
			exp_bits = 5'(wu.time_code) + `WU_HS_EXP_OFS;
		else if (wu.time_code < `WU_LS_HI_CODE)
			exp_bits = 5'(wu.time_code) + `WU_LS_EXP_LO;
		else
			exp_bits = 5'(wu.time_code) + `WU_LS_EXP_HI;
		last_count = (`WU_CNT_W'(1) << exp_bits) - `WU_CNT_W'(1);
		tick = wu.use_ls ? wu.ls_tick : wu.hs_tick;
		nxt_count = count_ff;
		nxt_running = running_ff;
		if (wu.start)
		begin
			nxt_count = '0;
			nxt_running = (wu.time_code != `WU_NONE);
		end
		else if (running_ff && tick)
		begin
			if (count_ff == last_count)
				nxt_running = 1'b0;
			else
				nxt_count = count_ff + `WU_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			count_ff <= '0;
			running_ff <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			running_ff <= nxt_running;
		end
	end

	assign wu.running = running_ff;
endmodule

//--- sim/clk_source_ctrl_assertions.sv
// Port-level assertion checker for the clock source selector
`timescale 1ns/1ps
`include "clk_sel_regs.svh"
module clk_source_ctrl_assertions
	import clk_sel_pkg::*;
(
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	// Register port
	input wire logic [7:0]  addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [31:0] rdata_out,
	// Oscillator ticks and low-power control
	input wire logic        hs_osc_tick_in,
	input wire logic        ls_osc_tick_in,
	input wire logic        lp_enter_in,
	input wire logic        wake_irq_in,
	// Watched outputs
	input wire logic        hs_osc_enable_out,
	input wire logic        ls_osc_enable_out,
	input wire logic        multiplier_power_on_out,
	input wire logic        high_speed_clock_out,
	input wire logic        sysclk_tick_out,
	input wire logic        core_free_clock_out,
	input wire logic        prescaler_input_clock_out,
	input wire logic        tick_timer_clock_out,
	input wire logic [2:0]  power_mode_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	rd_idle_zero_a: assert property (
		!$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data not zero outside read slot");
	unmapped_zero_a: assert property (
		$past(rd_in) && $past(addr_in) > `ADDR_STBY_CTRL |-> rdata_out == 32'h0)
		else $error("unmapped read not zero");
	reset_state_a: assert property (
		$past(sys_rst_in) |-> power_mode_out == PM_RUN && hs_osc_enable_out
		&& ls_osc_enable_out && !multiplier_power_on_out)
		else $error("wrong state after reset");
	pll_off_sleep_a: assert property (
		power_mode_out inside {PM_SLEEP, PM_STOP} && $stable(power_mode_out)
		|-> !multiplier_power_on_out)
		else $error("multiplier powered in sleep or stop");
	sys_gated_a: assert property (
		power_mode_out inside {PM_SLEEP, PM_STOP, PM_WARMUP}
		&& $stable(power_mode_out) |-> !sysclk_tick_out
		&& !prescaler_input_clock_out && !core_free_clock_out)
		else $error("system ticks while stopped");
	core_run_only_a: assert property (
		core_free_clock_out |-> power_mode_out == PM_RUN
		|| $past(power_mode_out) == PM_RUN)
		else $error("core tick outside run");
	wake_warmup_a: assert property (
		power_mode_out inside {PM_SLEEP, PM_STOP} && wake_irq_in
		|=> power_mode_out == PM_WARMUP)
		else $error("wake did not enter warm-up");
	idle_wake_a: assert property (
		power_mode_out == PM_IDLE && wake_irq_in |=> power_mode_out == PM_RUN)
		else $error("idle wake did not resume");
	tick_spacing_a: assert property (
		tick_timer_clock_out |=> !tick_timer_clock_out [*8])
		else $error("tick timer pulses too close");
endmodule

//--- sim/clk_source_ctrl_tb.sv
// Self-checking bench for the clock source selector
`timescale 1ns/1ps
`include "clk_sel_regs.svh"
module clk_source_ctrl_tb;
	import clk_sel_pkg::*;
	logic        clk_in, sys_rst_in, wr_in, rd_in, lp_enter_in, wake_irq_in;
	logic        hs_osc_tick_in, ls_osc_tick_in;
	logic [7:0]  addr_in;
	logic [31:0] wdata_in, rdata_out;
	logic        hs_osc_enable_out, ls_osc_enable_out, multiplier_power_on_out;
	logic        high_speed_clock_out, sysclk_tick_out, core_free_clock_out;
	logic        prescaler_input_clock_out, tick_timer_clock_out;
	logic [2:0]  power_mode_out;
	int          miscompares = 0;
	int          compares = 0;
	int          hs_cnt = 0;
	int          ls_cnt = 0;

	clk_source_ctrl uut (.*);

	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// Oscillators: high speed every 8 cycles, low speed every 20
	always @(posedge clk_in)
	begin
		hs_cnt <= (hs_cnt + 1) % 8;
		ls_cnt <= (ls_cnt + 1) % 20;
		hs_osc_tick_in <= (hs_cnt == 7);
		ls_osc_tick_in <= (ls_cnt == 19);
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask

	task automatic rdx(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask

	// Window lengths are whole periods so phase cannot shift the counts
	task automatic measure(input int w, eck, esy, epr, ett, eco);
		int n[5];
		n = '{0, 0, 0, 0, 0};
		repeat (64) @(posedge clk_in);
		repeat (w)
		begin
			@(negedge clk_in);
			n[0] += high_speed_clock_out;
			n[1] += sysclk_tick_out;
			n[2] += prescaler_input_clock_out;
			n[3] += tick_timer_clock_out;
			n[4] += core_free_clock_out;
		end
		if (eck >= 0) chk("hs clock", eck, n[0]);
		if (esy >= 0) chk("sys clock", esy, n[1]);
		if (epr >= 0) chk("prescaler", epr, n[2]);
		if (ett >= 0) chk("tick timer", ett, n[3]);
		if (eco >= 0) chk("core clock", eco, n[4]);
	endtask

	task automatic warm(input logic [31:0] d, input int exp);
		logic [31:0] r;
		int          n;
		wr(`ADDR_OSC_CTRL, d);
		n = 0;
		do
		begin
			rd(`ADDR_OSC_CTRL, r);
			n += 2;
		end while (r[1] === 1'b1 && n < 30000);
		chk("warm-up ok", 32'h1, {31'h0, n > exp - 24 && n < exp + 24});
		chk("osc ctrl", d & 32'hFFFF_FFFE, r);
	endtask

	task automatic wait_flag(input logic v);
		logic [31:0] r;
		int          n;
		n = 0;
		do
		begin
			rd(`ADDR_SYS_SEL, r);
			n++;
		end while (r[0] !== v && n < 50);
		chk("sys select", {30'h0, v, v}, r);
	endtask

	task automatic pulse(input bit wake);
		@(posedge clk_in);
		if (wake) wake_irq_in <= 1'b1;
		else lp_enter_in <= 1'b1;
		@(posedge clk_in);
		wake_irq_in <= 1'b0;
		lp_enter_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	task automatic t_sleep;
		int n;
		wr(`ADDR_OSC_CTRL, 32'h314);
		wr(`ADDR_STBY_CTRL, 32'h2);
		pulse(0);
		chk("mode", PM_SLEEP, power_mode_out);
		chk("pll power", 32'h0, multiplier_power_on_out);
		measure(64, -1, 0, 0, -1, 0);
		pulse(1);
		chk("mode", PM_WARMUP, power_mode_out);
		measure(64, -1, 0, 0, -1, 0);
		n = 130;
		while (power_mode_out !== PM_RUN && n < 12000)
		begin
			@(negedge clk_in);
			n++;
		end
		chk("wake span ok", 32'h1, {31'h0, n > 8150 && n < 8260});
		chk("pll power", 32'h1, multiplier_power_on_out);
		wr(`ADDR_STBY_CTRL, 32'h3);
		pulse(0);
		chk("mode", PM_IDLE, power_mode_out);
		measure(64, -1, -1, -1, -1, 0);
		pulse(1);
		chk("mode", PM_RUN, power_mode_out);
		wr(`ADDR_OSC_CTRL, 32'h100);
		wr(`ADDR_STBY_CTRL, 32'h1);
		pulse(0);
		chk("mode", PM_STOP, power_mode_out);
		chk("hs osc enable", 32'h0, hs_osc_enable_out);
		chk("ls osc enable", 32'h0, ls_osc_enable_out);
		pulse(1);
		chk("mode", PM_RUN, power_mode_out);
		chk("hs osc enable", 32'h1, hs_osc_enable_out);
		wr(`ADDR_OSC_CTRL, 32'h300);
	endtask

	task automatic finish_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge clk_in);
		miscompares++;
		$display("CHECK FAILED watchdog expected done seen timeout");
		finish_test;
	end

	initial
	begin
		{sys_rst_in, wr_in, rd_in, lp_enter_in, wake_irq_in} = 5'h10;
		{addr_in, wdata_in} = '0;
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rdx(`ADDR_OSC_CTRL, 32'h300);
		rdx(`ADDR_PLL_SEL, 32'h0);
		rdx(`ADDR_SYS_SEL, 32'h0);
		rdx(`ADDR_DIV_CTRL, 32'h0);
		rdx(`ADDR_STBY_CTRL, 32'h3);
		chk("hs osc enable", 32'h1, hs_osc_enable_out);
		chk("ls osc enable", 32'h1, ls_osc_enable_out);
		chk("pll power", 32'h0, multiplier_power_on_out);
		measure(256, 32, 32, 32, 1, 32);
		wr(`ADDR_PLL_SEL, 32'hFFFF_FFFF);
		rdx(`ADDR_PLL_SEL, 32'h1);
		wr(`ADDR_PLL_SEL, 32'h0);
		wr(`ADDR_SYS_SEL, 32'h1);
		rdx(`ADDR_SYS_SEL, 32'h0);
		wr(8'h40, 32'hFFFF_FFFF);
		rdx(8'h40, 32'h0);
		warm(32'h310, 0);
		warm(32'h311, 8192);
		warm(32'h319, 1280);
		for (int g = 0; g < 4; g++)
		begin
			wr(`ADDR_DIV_CTRL, g);
			measure(256, 32, 32 >> g, 32 >> g, 1, 32 >> g);
		end
		wr(`ADDR_DIV_CTRL, 32'h50);
		measure(256, 32, 32, 1, 1, 32);
		wr(`ADDR_DIV_CTRL, 32'h0);
		warm(32'h315, 8192);
		wr(`ADDR_PLL_SEL, 32'h1);
		measure(256, 128, 128, 128, 1, 128);
		wr(`ADDR_PLL_SEL, 32'h0);
		warm(32'h319, 1280);
		wr(`ADDR_SYS_SEL, 32'h2);
		wait_flag(1'b1);
		measure(260, -1, 13, -1, -1, 13);
		wr(`ADDR_SYS_SEL, 32'h0);
		wait_flag(1'b0);
		t_sleep;
		finish_test;
	end
endmodule

bind clk_source_ctrl clk_source_ctrl_assertions chk_i (.*);
